// *** vis_pkg.sv ***
// Purpose: Shared constants for the vectored interrupt sequencer
// Assumes: 8-bit register file addressing, 16-bit program counter
// Notes:   Offsets are register file addresses
package vis_pkg;
  localparam logic [7:0] FAST_PTR_HI_ADDR  = 8'hDA;
  localparam logic [7:0] FAST_PTR_LO_ADDR  = 8'hDB;
  localparam logic [7:0] REQ_STATUS_ADDR   = 8'hDC;
  localparam logic [7:0] LEVEL_MASK_ADDR   = 8'hDD;
  localparam logic [7:0] SYS_MODE_ADDR     = 8'hDE;
  localparam int         GIE_BIT           = 0;
  localparam int         FIE_BIT           = 1;
  localparam int         FLS_LO            = 2;
  localparam int         FLS_HI            = 4;
  localparam int         FAST_FLAG_BIT     = 1;
  localparam logic [7:0] SYS_MODE_RST      = 8'h00;
  localparam logic [7:0] REQ_STATUS_RST    = 8'h00;
  localparam logic [7:0] LEVEL_MASK_RST    = 8'h00;
  localparam logic [7:0] VECTOR_BASE       = 8'h00;
  localparam int         FAST_ENTRY_CYC    = 6;
  localparam int         NORMAL_ENTRY_CYC  = 16;
  localparam logic [3:0] FAST_ENTRY_LAST   = 4'(FAST_ENTRY_CYC - 1);
  localparam logic [3:0] NORMAL_ENTRY_LAST = 4'(NORMAL_ENTRY_CYC - 1);
  localparam logic [3:0] PUSH_PCL_STEP     = 4'h1;
  localparam logic [3:0] PUSH_PCH_STEP     = 4'h2;
  localparam logic [3:0] PUSH_FLG_STEP     = 4'h3;
  localparam logic [3:0] VEC_HI_STEP       = 4'h5;
  localparam logic [3:0] VEC_LO_STEP       = 4'h6;

  typedef enum logic [4:0] {
    ST_RUN    = 5'h01,
    ST_NORMAL = 5'h02,
    ST_FAST   = 5'h04,
    ST_RETN   = 5'h08,
    ST_RETF   = 5'h10
  } vis_state_t;
endpackage

// *** vis_prio_pick.sv ***
// Purpose: Fixed priority picker over eight interrupt levels
// Assumes: Level 0 highest unless a priority order is given outside
// Notes:   Group priority encoding stays with the caller
`timescale 1ns/1ns
module vis_prio_pick #(
  parameter int LEVELS = 8
) (
  // Requests
  input  wire logic [LEVELS-1:0]         i_req,
  // Winner
  output logic                           o_any,
  output logic [$clog2(LEVELS)-1:0]      o_level
);
  always_comb begin
    o_any   = 1'b0;
    o_level = '0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any   = 1'b1;
        o_level = ($clog2(LEVELS))'(i);
      end
    end
  end
endmodule

// *** vis_sequencer.sv ***
// Purpose: CPU-side interrupt sequencing: acknowledge, entry cycle, return
// Assumes: Core drives instruction boundary and return strobes, stack
//          and program memory answer combinationally in the same cycle
// Function
// - Service needs global enable, level mask, top priority and source enable.
// - Acknowledge only at the end of the current instruction.
// - Entry cycle clears the global enable bit.
// - Vectored entry pushes PC low, PC high, then flags.
// - Then reads vector high then low byte and branches there.
// - Vectors sit in 00H-0FH at even addresses.
// - Return restores PC and flags and sets global enable.
// - Order: request, poll, level check, acknowledge, vector, keep polling.
// - Mode bits 4..2 choose fast level, bit 1 enables fast handling.
// - Fast entry about 6 cycles, normal entry about 16 cycles.
// - Fast pointer is a pair at DAH (high) and DBH (low).
// - Fast entry swaps pointer and PC, saves flags, sets fast status.
// - Fast return swaps back, restores shadow flags, clears fast status.
// - Any of the eight levels may be chosen for fast handling.
// - Fast handling works with hardware and software cleared pending bits.
// - Only the fast enable bit gates fast mode; global enable gates all.
// - Level 0 pending is hardware set, hidden, cleared on service.
// - Mask bit n gates level n; one enables it.
// - Request status is read-only, per level, readable always, reset clear.
`timescale 1ns/1ns
module vis_sequencer #(
  parameter int LEVELS = 8
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Interrupt requests, already gated by source enables
  input  wire logic [LEVELS-1:0] i_src_req,
  // Core handshake
  input  wire logic              i_instr_end,
  input  wire logic              i_return_from_interrupt,
  input  wire logic              i_ei,
  input  wire logic              i_di,
  input  wire logic [15:0]       i_pc,
  input  wire logic [7:0]        i_flags,
  // Stack and program memory data
  input  wire logic [7:0]        i_stack_rdata,
  input  wire logic [7:0]        i_rom_rdata,
  // Register file port
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  // Core control outputs
  output logic                   o_busy,
  output logic                   o_iack,
  output logic [2:0]             o_iack_level,
  output logic                   o_stack_push,
  output logic                   o_stack_pop,
  output logic [7:0]             o_stack_wdata,
  output logic                   o_rom_rd,
  output logic [7:0]             o_rom_addr,
  output logic                   o_pc_load,
  output logic [15:0]            o_pc,
  output logic                   o_flags_load,
  output logic [7:0]             o_flags
);
  vis_pkg::vis_state_t state_ff;
  vis_pkg::vis_state_t nxt_state;
  logic [3:0]        step_ff;
  logic [7:0]        sys_mode_ff;
  logic [7:0]        mask_ff;
  logic [7:0]        req_stat_ff;
  logic              lvl0_pend_ff;
  logic [15:0]       fast_ptr_ff;
  logic [7:0]        shadow_flags_ff;
  logic [7:0]        vec_hi_ff;
  logic [7:0]        ret_flags_ff;
  logic [7:0]        ret_pch_ff;
  logic [2:0]        lvl_ff;
  logic [LEVELS-1:0] eligible;
  logic              any_req;
  logic [2:0]        win_level;
  logic              take;
  logic              take_fast;
  logic              fast_active;
  logic              ret_go;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = i_reg_wr && (a == b);
  endfunction

  // One step of one sequence; shared by the datapath captures
  function automatic logic at_step(input vis_pkg::vis_state_t s, input logic [3:0] n);
    at_step = (state_ff == s) && (step_ff == n);
  endfunction

  // Vector pair of a level; the even byte holds the high half
  function automatic logic [7:0] vec_addr(input logic [2:0] lvl, input logic lo);
    vec_addr = 8'(vis_pkg::VECTOR_BASE + {4'h0, lvl, lo});
  endfunction

  // Level 0 is hardware cleared and seen only through status; others follow the source
  assign eligible = req_stat_ff & mask_ff;
  vis_prio_pick #(.LEVELS(LEVELS)) u_pick (
    .i_req   (eligible),
    .o_any   (any_req),
    .o_level (win_level)
  );
  assign fast_active = i_flags[vis_pkg::FAST_FLAG_BIT];
  // Only taken between instructions, with global enable set
  assign take = (state_ff == vis_pkg::ST_RUN) && i_instr_end && any_req
                && sys_mode_ff[vis_pkg::GIE_BIT];
  assign take_fast = sys_mode_ff[vis_pkg::FIE_BIT]
                     && (win_level == sys_mode_ff[vis_pkg::FLS_HI:vis_pkg::FLS_LO]);
  // An entry wins the edge; a return is only seen between sequences
  assign ret_go = (state_ff == vis_pkg::ST_RUN) && !take && i_return_from_interrupt;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl0_pend_ff <= 1'b0;
    end else if (i_src_req[0]) begin
      lvl0_pend_ff <= 1'b1;
    end else if (take && win_level == 3'h0) begin
      lvl0_pend_ff <= 1'b0;
    end
  end

  // Set wins over clear for level 0
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_stat_ff <= vis_pkg::REQ_STATUS_RST;
    end else begin
      req_stat_ff <= {i_src_req[LEVELS-1:1], lvl0_pend_ff | i_src_req[0]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_ff <= vis_pkg::LEVEL_MASK_RST;
    end else if (hit(i_reg_addr, vis_pkg::LEVEL_MASK_ADDR)) begin
      mask_ff <= i_reg_wdata;
    end
  end

  // Entry and return outrank the core strobes and register writes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_mode_ff <= vis_pkg::SYS_MODE_RST;
    end else if (take) begin
      sys_mode_ff[vis_pkg::GIE_BIT] <= 1'b0;
    end else if (state_ff == vis_pkg::ST_RETN || state_ff == vis_pkg::ST_RETF) begin
      if (step_ff == 4'h0) begin
        sys_mode_ff[vis_pkg::GIE_BIT] <= 1'b1;
      end
    end else if (i_ei) begin
      sys_mode_ff[vis_pkg::GIE_BIT] <= 1'b1;
    end else if (i_di) begin
      sys_mode_ff[vis_pkg::GIE_BIT] <= 1'b0;
    end else if (hit(i_reg_addr, vis_pkg::SYS_MODE_ADDR)) begin
      sys_mode_ff <= i_reg_wdata;
    end
  end

  // Pointer swaps with the PC on fast entry and fast return
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fast_ptr_ff <= 16'h0000;
    end else if (at_step(vis_pkg::ST_FAST, 4'h0)
                 || at_step(vis_pkg::ST_RETF, 4'h0)) begin
      fast_ptr_ff <= i_pc;
    end else if (hit(i_reg_addr, vis_pkg::FAST_PTR_HI_ADDR)) begin
      fast_ptr_ff[15:8] <= i_reg_wdata;
    end else if (hit(i_reg_addr, vis_pkg::FAST_PTR_LO_ADDR)) begin
      fast_ptr_ff[7:0] <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shadow_flags_ff <= 8'h00;
    end else if (at_step(vis_pkg::ST_FAST, 4'h0)) begin
      shadow_flags_ff <= i_flags;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_ff <= 3'h0;
    end else if (take) begin
      lvl_ff <= win_level;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vis_pkg::ST_RUN: begin
        if (take) begin
          nxt_state = take_fast ? vis_pkg::ST_FAST : vis_pkg::ST_NORMAL;
        end else if (ret_go) begin
          nxt_state = fast_active ? vis_pkg::ST_RETF : vis_pkg::ST_RETN;
        end
      end
      vis_pkg::ST_NORMAL: begin
        if (step_ff == vis_pkg::NORMAL_ENTRY_LAST) begin
          nxt_state = vis_pkg::ST_RUN;
        end
      end
      vis_pkg::ST_FAST: begin
        if (step_ff == vis_pkg::FAST_ENTRY_LAST) begin
          nxt_state = vis_pkg::ST_RUN;
        end
      end
      vis_pkg::ST_RETN: begin
        if (step_ff == 4'h3) begin
          nxt_state = vis_pkg::ST_RUN;
        end
      end
      vis_pkg::ST_RETF: nxt_state = vis_pkg::ST_RUN;
      default: nxt_state = vis_pkg::ST_RUN;
    endcase
  end

  // Step restarts on every state change, so each sequence counts from zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= vis_pkg::ST_RUN;
      step_ff  <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      step_ff  <= (nxt_state != state_ff) ? 4'h0 : 4'(step_ff + 4'h1);
    end
  end

  // Vector high byte and popped bytes held for the concatenation
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vec_hi_ff    <= 8'h00;
      ret_flags_ff <= 8'h00;
      ret_pch_ff   <= 8'h00;
    end else begin
      if (at_step(vis_pkg::ST_NORMAL, vis_pkg::VEC_HI_STEP)) begin
        vec_hi_ff <= i_rom_rdata;
      end
      if (at_step(vis_pkg::ST_RETN, 4'h1)) begin
        ret_flags_ff <= i_stack_rdata;
      end
      if (at_step(vis_pkg::ST_RETN, 4'h2)) begin
        ret_pch_ff <= i_stack_rdata;
      end
    end
  end

  // Registered core controls
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_iack       <= 1'b0;
      o_iack_level <= 3'h0;
      o_stack_push <= 1'b0;
      o_stack_pop  <= 1'b0;
      o_stack_wdata <= 8'h00;
      o_rom_rd     <= 1'b0;
      o_rom_addr   <= 8'h00;
      o_pc_load    <= 1'b0;
      o_pc         <= 16'h0000;
      o_flags_load <= 1'b0;
      o_flags      <= 8'h00;
      o_busy       <= 1'b0;
    end else begin
      o_iack       <= take;
      o_iack_level <= take ? win_level : o_iack_level;
      o_stack_push <= 1'b0;
      o_stack_pop  <= 1'b0;
      o_rom_rd     <= 1'b0;
      o_pc_load    <= 1'b0;
      o_flags_load <= 1'b0;
      o_busy       <= (nxt_state != vis_pkg::ST_RUN);
      case (state_ff)
        vis_pkg::ST_NORMAL: begin
          if (step_ff == vis_pkg::PUSH_PCL_STEP) begin
            o_stack_push  <= 1'b1;
            o_stack_wdata <= i_pc[7:0];
          end else if (step_ff == vis_pkg::PUSH_PCH_STEP) begin
            o_stack_push  <= 1'b1;
            o_stack_wdata <= i_pc[15:8];
          end else if (step_ff == vis_pkg::PUSH_FLG_STEP) begin
            o_stack_push  <= 1'b1;
            o_stack_wdata <= i_flags;
          end else if (step_ff == 4'h4) begin
            o_rom_rd   <= 1'b1;
            o_rom_addr <= vec_addr(lvl_ff, 1'b0);
          end else if (step_ff == vis_pkg::VEC_HI_STEP) begin
            o_rom_rd   <= 1'b1;
            o_rom_addr <= vec_addr(lvl_ff, 1'b1);
          end else if (step_ff == vis_pkg::VEC_LO_STEP) begin
            o_pc_load <= 1'b1;
            o_pc      <= {vec_hi_ff, i_rom_rdata};
          end
        end
        vis_pkg::ST_FAST: begin
          if (step_ff == 4'h0) begin
            o_pc_load    <= 1'b1;
            o_pc         <= fast_ptr_ff;
            o_flags_load <= 1'b1;
            o_flags      <= i_flags | (8'h01 << vis_pkg::FAST_FLAG_BIT);
          end
        end
        vis_pkg::ST_RETN: begin
          o_stack_pop <= (step_ff < 4'h3);
          if (step_ff == 4'h3) begin
            o_pc_load    <= 1'b1;
            o_pc         <= {ret_pch_ff, i_stack_rdata};
            o_flags_load <= 1'b1;
            o_flags      <= ret_flags_ff;
          end
        end
        vis_pkg::ST_RETF: begin
          o_pc_load    <= 1'b1;
          o_pc         <= fast_ptr_ff;
          o_flags_load <= 1'b1;
          o_flags      <= shadow_flags_ff & ~(8'h01 << vis_pkg::FAST_FLAG_BIT);
        end
        default: begin
        end
      endcase
    end
  end

  // Read data; level 0 pending stays hidden except through status
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        vis_pkg::FAST_PTR_HI_ADDR: o_reg_rdata <= fast_ptr_ff[15:8];
        vis_pkg::FAST_PTR_LO_ADDR: o_reg_rdata <= fast_ptr_ff[7:0];
        vis_pkg::REQ_STATUS_ADDR:  o_reg_rdata <= req_stat_ff;
        vis_pkg::LEVEL_MASK_ADDR:  o_reg_rdata <= mask_ff;
        vis_pkg::SYS_MODE_ADDR:    o_reg_rdata <= sys_mode_ff;
        default:                   o_reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// *** vis_seq_assertions.sv ***
// Purpose: Port-level checks on the interrupt sequencer
// Assumes: Core holds pc and flags steady while the sequencer is busy
// Notes:   Entry length judged from busy width after acknowledge
`timescale 1ns/1ns
module vis_seq_checker (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Core side
  input  wire logic        i_instr_end,
  input  wire logic        i_return_from_interrupt,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_flags,
  input  wire logic [7:0]  i_stack_rdata,
  input  wire logic [7:0]  i_rom_rdata,
  // Sequencer outputs
  input  wire logic        o_busy,
  input  wire logic        o_iack,
  input  wire logic [2:0]  o_iack_level,
  input  wire logic        o_stack_push,
  input  wire logic        o_stack_pop,
  input  wire logic [7:0]  o_stack_wdata,
  input  wire logic        o_rom_rd,
  input  wire logic [7:0]  o_rom_addr,
  input  wire logic        o_pc_load,
  input  wire logic [15:0] o_pc,
  input  wire logic        o_flags_load,
  input  wire logic [7:0]  o_flags
);
  logic [4:0] cnt_ff;
  logic       ent_ff;
  logic       fst_ff;
  logic       fld;
  assign fld = o_pc_load && o_flags_load && o_flags[1];
  // Fast entry may load in the acknowledge cycle itself
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 5'h00;
      ent_ff <= 1'h0;
      fst_ff <= 1'h0;
    end else begin
      cnt_ff <= o_busy ? cnt_ff + 5'h01 : 5'h00;
      ent_ff <= o_iack || (o_busy && ent_ff);
      fst_ff <= o_iack ? fld : (fst_ff || (ent_ff && fld));
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_push3;
    o_stack_wdata == i_pc[7:0] ##1 o_stack_push && o_stack_wdata == i_pc[15:8]
    ##1 o_stack_push && o_stack_wdata == i_flags;
  endsequence
  sequence s_fetch;
    o_rom_rd && o_rom_addr == {4'h0, o_iack_level, 1'h0}
    ##1 o_rom_rd && o_rom_addr == {4'h0, o_iack_level, 1'h1} ##1 o_pc_load;
  endsequence
  sequence s_pop3;
    o_stack_pop [*3];
  endsequence
  property p_take_edge;
    o_iack |-> $past(i_instr_end) && !$past(o_busy);
  endproperty
  property p_iack_start;
    o_iack |-> $rose(o_busy) ##1 !o_iack;
  endproperty
  property p_vec_order;
    o_stack_push && !$past(o_stack_push) |-> s_push3 ##1 s_fetch;
  endproperty
  property p_vec_target;
    o_pc_load && $past(o_rom_rd) |-> o_pc == {$past(i_rom_rdata, 2), $past(i_rom_rdata)};
  endproperty
  property p_vec_range;
    o_rom_rd |-> o_rom_addr[7:4] == 4'h0;
  endproperty
  property p_entry_len;
    $fell(o_busy) && ent_ff |-> cnt_ff == (fst_ff ? 5'h06 : 5'h10);
  endproperty
  property p_fast_entry;
    fld && (ent_ff || o_iack) |-> o_flags == (i_flags | 8'h02) && !o_stack_push;
  endproperty
  property p_ret_norm;
    i_return_from_interrupt && !o_busy && !i_flags[1] |=> ##1 s_pop3 ##1 o_pc_load && o_flags_load
    && o_pc == {$past(i_stack_rdata, 2), $past(i_stack_rdata)} && o_flags == $past(i_stack_rdata, 3);
  endproperty
  property p_ret_fast;
    i_return_from_interrupt && !o_busy && i_flags[1] |-> ##[1:4] o_pc_load && o_flags_load && !o_flags[1];
  endproperty
  a_take_edge: assert property (p_take_edge) else $error("iack off boundary");
  a_iack_start: assert property (p_iack_start) else $error("iack not a single pulse");
  a_vec_order: assert property (p_vec_order) else $error("push or fetch order wrong");
  a_vec_target: assert property (p_vec_target) else $error("branch target wrong");
  a_vec_range: assert property (p_vec_range) else $error("vector out of area");
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
  a_fast_entry: assert property (p_fast_entry) else $error("fast entry flags wrong");
  a_ret_norm: assert property (p_ret_norm) else $error("return restore wrong");
  a_ret_fast: assert property (p_ret_fast) else $error("fast return wrong");
endmodule

bind vis_sequencer vis_seq_checker i_vis_seq_checker (
  .i_mclk, .i_rst_n, .i_instr_end, .i_return_from_interrupt, .i_pc, .i_flags, .i_stack_rdata, .i_rom_rdata,
  .o_busy, .o_iack, .o_iack_level, .o_stack_push, .o_stack_pop, .o_stack_wdata, .o_rom_rd,
  .o_rom_addr, .o_pc_load, .o_pc, .o_flags_load, .o_flags
);

// *** vis_core_model.sv ***
// Purpose: Core and memory stand-in facing the sequencer
// Assumes: Stack and vector memory answer in the same cycle
// Notes:   Idle stack bus toggles instead of keeping the last byte
`timescale 1ns/1ns
module vis_core_model (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // From sequencer
  input  wire logic        i_busy,
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rom_rd,
  input  wire logic [7:0]  i_rom_addr,
  input  wire logic        i_pc_load,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_flags_load,
  input  wire logic [7:0]  i_flags,
  // To sequencer
  output logic             o_instr_end,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_flags,
  output logic [7:0]       o_stack_rdata,
  output logic [7:0]       o_rom_rdata
);
  logic [7:0] stk_ff [0:15];
  logic [3:0] sp_ff;
  logic [1:0] div_ff;
  logic       tgl_ff;
  // PC moves mid-instruction only, so it is steady at every boundary
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff  <= 2'h0;
      tgl_ff  <= 1'h0;
      o_pc    <= 16'h0100;
      o_flags <= 8'h00;
    end else begin
      div_ff <= i_busy ? 2'h0 : div_ff + 2'h1;
      tgl_ff <= ~tgl_ff;
      if (i_pc_load) begin
        o_pc <= i_pc;
      end else if (!i_busy && div_ff == 2'h1) begin
        o_pc <= o_pc + 16'h0003;
      end
      if (i_flags_load) begin
        o_flags <= i_flags;
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_ff <= 4'h0;
    end else if (i_push) begin
      stk_ff[sp_ff] <= i_wdata;
      sp_ff         <= sp_ff + 4'h1;
    end else if (i_pop) begin
      sp_ff <= sp_ff - 4'h1;
    end
  end
  assign o_instr_end   = !i_busy && div_ff == 2'h3;
  assign o_stack_rdata = i_pop ? stk_ff[sp_ff - 4'h1] : {8{tgl_ff}};
  assign o_rom_rdata   = !i_rom_rd ? ~i_rom_addr : ((i_rom_addr[0] ? 8'h40 : 8'h80) | i_rom_addr);
endmodule

// *** vectored_interrupt_sequencer_bench.sv ***
// Purpose: Self-checking bench for the interrupt sequencer
// Assumes: Core stand-in answers stack and vector reads
// Notes:   All levels swept in both modes, pointers and rivals random
`timescale 1ns/1ns
module vectored_interrupt_sequencer_bench;
  logic        i_mclk      = 1'h0;
  logic        i_rst_n     = 1'h0;
  logic [7:0]  i_src_req   = 8'h00;
  logic        i_return_from_interrupt      = 1'h0;
  logic        i_ei        = 1'h0;
  logic        i_di        = 1'h0;
  logic        i_reg_wr    = 1'h0;
  logic        i_reg_rd    = 1'h0;
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_instr_end, o_busy, o_iack, o_stack_push, o_stack_pop, o_rom_rd;
  logic        o_pc_load, o_flags_load;
  logic [2:0]  o_iack_level;
  logic [7:0]  i_flags, i_stack_rdata, i_rom_rdata, o_reg_rdata, o_stack_wdata, o_rom_addr;
  logic [7:0]  o_flags, rd, exp_flg;
  logic [15:0] i_pc, o_pc, ptr, exp_pc;
  int          bad_count   = 0;
  int          cmp_count   = 0;
  int          lv2;
  integer      seed        = 32'hABF1;

  always #50 i_mclk = ~i_mclk;

  vis_sequencer #(.LEVELS(8)) i_vis_sequencer (
    .i_mclk, .i_rst_n, .i_src_req, .i_instr_end, .i_return_from_interrupt, .i_ei, .i_di, .i_pc, .i_flags,
    .i_stack_rdata, .i_rom_rdata, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_busy, .o_iack, .o_iack_level, .o_stack_push, .o_stack_pop, .o_stack_wdata, .o_rom_rd,
    .o_rom_addr, .o_pc_load, .o_pc, .o_flags_load, .o_flags
  );
  vis_core_model i_vis_core_model (
    .i_mclk, .i_rst_n, .i_busy(o_busy), .i_push(o_stack_push), .i_pop(o_stack_pop),
    .i_wdata(o_stack_wdata), .i_rom_rd(o_rom_rd), .i_rom_addr(o_rom_addr), .i_pc_load(o_pc_load),
    .i_pc(o_pc), .i_flags_load(o_flags_load), .i_flags(o_flags), .o_instr_end(i_instr_end),
    .o_pc(i_pc), .o_flags(i_flags), .o_stack_rdata(i_stack_rdata), .o_rom_rdata(i_rom_rdata)
  );

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] stk(input logic [3:0] back);
    return i_vis_core_model.stk_ff[i_vis_core_model.sp_ff - back];
  endfunction
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr    <= 1'h1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'h0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_reg_rd   <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'h0;
    @(negedge i_mclk);
    d = o_reg_rdata;
  endtask
  // Core strobes: 0 enable, 1 disable, 2 return
  task automatic strobe(input int k);
    @(posedge i_mclk);
    i_ei   <= (k == 0);
    i_di   <= (k == 1);
    i_return_from_interrupt <= (k == 2);
    @(posedge i_mclk);
    i_ei   <= 1'h0;
    i_di   <= 1'h0;
    i_return_from_interrupt <= 1'h0;
  endtask
  task automatic expect_iack(input logic want);
    int n;
    n = 0;
    while (o_iack !== 1'h1 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    cmp_byte({7'h00, o_iack === 1'h1}, {7'h00, want});
  endtask
  // Busy cycles seen after the call edge; a hang counts as a mismatch
  task automatic wait_idle(output int n);
    n = 0;
    @(negedge i_mclk);
    while (o_busy !== 1'h0 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    cmp_byte({7'h00, o_busy}, 8'h00);
  endtask
  // One full service of level lv with a lower-priority rival lv2; lv2 falls back to lv past level 7, so level 7 has none
  task automatic serve(input int lv, input logic fst);
    int n;
    lv2 = lv + 1 + int'($unsigned($random(seed)) % 3);
    if (lv2 > 7) lv2 = lv;
    ptr = 16'($random(seed));
    reg_write(vis_pkg::FAST_PTR_HI_ADDR, ptr[15:8]);
    reg_write(vis_pkg::FAST_PTR_LO_ADDR, ptr[7:0]);
    reg_write(vis_pkg::SYS_MODE_ADDR, {3'h0, 3'(lv), fst, 1'h0});
    @(posedge i_mclk);
    i_src_req <= 8'(1 << lv) | 8'(1 << lv2);
    @(posedge i_mclk);
    i_src_req[0] <= 1'h0;
    expect_iack(1'h0);
    reg_read(vis_pkg::REQ_STATUS_ADDR, rd);
    cmp_byte(rd, 8'(1 << lv) | 8'(1 << lv2));
    strobe(0);
    expect_iack(1'h1);
    cmp_byte({5'h00, o_iack_level}, 8'(lv));
    exp_pc  = i_pc;
    exp_flg = i_flags;
    wait_idle(n);
    cmp_byte(8'(n + 1), 8'(fst ? vis_pkg::FAST_ENTRY_CYC : vis_pkg::NORMAL_ENTRY_CYC));
    if (fst) begin
      cmp_word(i_pc, ptr);
      cmp_byte(i_flags, exp_flg | 8'h02);
      reg_read(vis_pkg::FAST_PTR_HI_ADDR, rd);
      cmp_byte(rd, exp_pc[15:8]);
    end else begin
      cmp_word(i_pc, {8'h80 | 8'(2 * lv), 8'h41 | 8'(2 * lv)});
      cmp_word({stk(4'h3), stk(4'h2)}, {exp_pc[7:0], exp_pc[15:8]});
      cmp_byte(stk(4'h1), exp_flg);
    end
    reg_read(vis_pkg::SYS_MODE_ADDR, rd);
    cmp_byte(rd & 8'h01, 8'h00);
    @(posedge i_mclk);
    i_src_req <= 8'h00;
    strobe(2);
    wait_idle(n);
    // The load lands on the edge after busy drops
    @(negedge i_mclk);
    cmp_word(i_pc, exp_pc);
    cmp_byte(i_flags, exp_flg);
    reg_read(vis_pkg::SYS_MODE_ADDR, rd);
    cmp_byte(rd & 8'h01, 8'h01);
    reg_read(vis_pkg::REQ_STATUS_ADDR, rd);
    cmp_byte(rd, 8'h00);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    reg_read(vis_pkg::REQ_STATUS_ADDR, rd);
    cmp_byte(rd, vis_pkg::REQ_STATUS_RST);
    reg_write(vis_pkg::LEVEL_MASK_ADDR, 8'hFB);
    reg_read(vis_pkg::LEVEL_MASK_ADDR, rd);
    cmp_byte(rd, 8'hFB);
    strobe(0);
    @(posedge i_mclk);
    i_src_req <= 8'h04;
    expect_iack(1'h0);
    strobe(1);
    reg_read(vis_pkg::SYS_MODE_ADDR, rd);
    cmp_byte(rd & 8'h01, 8'h00);
    @(posedge i_mclk);
    i_src_req <= 8'h00;
    reg_write(vis_pkg::LEVEL_MASK_ADDR, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      serve(i % 8, i >= 8);
    end
    print_verdict;
  end
  // Sweep needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    print_verdict;
  end
endmodule
